/* File: hw/fpv_bus.sv */
// One write or read cycle on the flash pins
`include "fpv_defines.svh"
module fpv_bus (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Request
	input  wire logic                 go,
	input  wire logic                 wr,
	input  wire logic [`FPV_AW-1:0]   a,
	input  wire logic [7:0]           wd,
	output logic                      done,
	output logic [7:0]                rd,
	// Flash pins
	output logic [`FPV_AW-1:0]        fl_a,
	output logic [7:0]                fl_dq_o,
	output logic                      fl_dq_oe,
	input  wire logic [7:0]           fl_dq_i,
	output logic                      fl_ce_n,
	output logic                      fl_we_n,
	output logic                      fl_oe_n
);
	localparam logic [7:0] STRB_LAST = 8'(`FPV_STRB_CYC - 1);
	localparam logic [7:0] RACC_LAST = 8'(`FPV_RACC_CYC - 1);
	fpv_pkg::fpv_bus_st_t s;
	fpv_pkg::fpv_bus_st_t next_s;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		unique case (s.ph)
			fpv_pkg::BP_IDLE: begin
				if (go) begin
					next_s.ph = fpv_pkg::BP_SET;
					next_s.wr = wr;
					next_s.a = a;
					next_s.wd = wd;
					next_s.ce_n = 1'b0;
					next_s.dq_oe = wr;
				end
			end
			fpv_pkg::BP_SET: begin
				next_s.ph = fpv_pkg::BP_STRB;
				next_s.we_n = !s.wr;
				next_s.oe_n = s.wr;
				next_s.cnt = s.wr ? STRB_LAST : RACC_LAST;
			end
			fpv_pkg::BP_STRB: begin
				if (s.cnt == 8'h00) begin
					next_s.ph = fpv_pkg::BP_HOLD;
					next_s.we_n = 1'b1;
					next_s.oe_n = 1'b1;
					if (!s.wr) begin
						next_s.rd = fl_dq_i;
					end
				end else begin
					next_s.cnt = s.cnt - 1'b1;
				end
			end
			fpv_pkg::BP_HOLD: begin
				next_s.ph = fpv_pkg::BP_IDLE;
				next_s.ce_n = 1'b1;
				next_s.dq_oe = 1'b0;
				next_s.done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.ce_n <= 1'b1;
			s.we_n <= 1'b1;
			s.oe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;
	assign rd = s.rd;
	assign fl_a = s.a;
	assign fl_dq_o = s.wd;
	assign fl_dq_oe = s.dq_oe;
	assign fl_ce_n = s.ce_n;
	assign fl_we_n = s.we_n;
	assign fl_oe_n = s.oe_n;

	property p_we_with_ce;
		@(posedge clk) disable iff (rst)
		!s.we_n |-> !s.ce_n && s.dq_oe && s.oe_n;
	endproperty
	a_we_with_ce: assert property (p_we_with_ce)
		else $error("write strobe without chip enable");
endmodule : fpv_bus

/* File: hw/fpv_defines.svh */
// Constants of the flash programming host
`ifndef FPV_DEFINES_SVH
`define FPV_DEFINES_SVH
`define FPV_AW 17
`define FPV_TW 24
`define FPV_PCW 5
`define FPV_ECW 16
`define FPV_CLK_NS 100
`define FPV_STRB_NS 100
`define FPV_RACC_NS 200
`define FPV_PROG_NS 10000
`define FPV_VER_NS 6000
`define FPV_ERASE_NS 10000000
`define FPV_STRB_CYC ((`FPV_STRB_NS + `FPV_CLK_NS - 1) / `FPV_CLK_NS)
`define FPV_RACC_CYC ((`FPV_RACC_NS + `FPV_CLK_NS - 1) / `FPV_CLK_NS)
`define FPV_PROG_CYC ((`FPV_PROG_NS + `FPV_CLK_NS - 1) / `FPV_CLK_NS)
`define FPV_VER_CYC ((`FPV_VER_NS + `FPV_CLK_NS - 1) / `FPV_CLK_NS)
`define FPV_ERASE_CYC ((`FPV_ERASE_NS + `FPV_CLK_NS - 1) / `FPV_CLK_NS)
`define FPV_MAX_PULSE 25
`define FPV_MAX_ERASE 1000
`define FPV_CMD_READ 8'h00
`define FPV_CMD_SETUP_ERASE 8'h20
`define FPV_CMD_ERASE_VERIFY 8'ha0
`define FPV_CMD_SETUP_PROG 8'h40
`define FPV_CMD_PROG_VERIFY 8'hc0
`define FPV_CMD_RESET 8'hff
`define FPV_ERASED 8'hff
`define FPV_PREPROG 8'h00
`define FPV_START_ADDR 17'h00000
`define FPV_LAST_ADDR 17'h1ffff
`endif

/* File: hw/fpv_host.sv */
// Host sequencer for byte programming and chip erase of a flash memory
`include "fpv_defines.svh"
module fpv_host #(
	parameter logic [`FPV_AW-1:0]  LAST_ADDR = `FPV_LAST_ADDR,
	parameter logic [`FPV_TW-1:0]  ERASE_CYC = `FPV_TW'(`FPV_ERASE_CYC),
	parameter logic [`FPV_ECW-1:0] MAX_ERASE = `FPV_ECW'(`FPV_MAX_ERASE)
) (
	// Clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RST,
	// User request
	input  wire logic                 START,
	input  wire logic                 ERASE,
	input  wire logic [`FPV_AW-1:0]   ADDR,
	input  wire logic [7:0]           DATA,
	input  wire logic                 ABORT,
	// User status
	output logic                      BUSY,
	output logic                      DONE,
	output logic                      FAIL,
	// Flash pins
	output logic [`FPV_AW-1:0]        FL_A,
	output logic [7:0]                FL_DQ_O,
	output logic                      FL_DQ_OE,
	input  wire logic [7:0]           FL_DQ_I,
	output logic                      FL_CE_N,
	output logic                      FL_WE_N,
	output logic                      FL_OE_N,
	output logic                      FL_VPP_EN
);
	localparam logic [`FPV_TW-1:0] PROG_CYC = `FPV_TW'(`FPV_PROG_CYC);
	localparam logic [`FPV_TW-1:0] VER_CYC = `FPV_TW'(`FPV_VER_CYC);
	localparam logic [`FPV_PCW-1:0] PULSE_LAST =
		`FPV_PCW'(`FPV_MAX_PULSE - 1);
	localparam logic [`FPV_ECW-1:0] ERASE_LAST = MAX_ERASE - 1'b1;

	fpv_pkg::fpv_host_st_t s;
	fpv_pkg::fpv_host_st_t next_s;
	logic                  bus_done;
	logic [7:0]            bus_rd;
	logic                  tm_done;

	// Launch one bus cycle, then move on when it completes
	function automatic fpv_pkg::fpv_host_st_t bus_step(
		input fpv_pkg::fpv_host_st_t c,
		input logic                  bd,
		input logic                  w,
		input logic [`FPV_AW-1:0]    ad,
		input logic [7:0]            dd,
		input fpv_pkg::fpv_mst_t     nx);
		fpv_pkg::fpv_host_st_t r;
		r = c;
		if (!c.issued) begin
			r.go = 1'b1;
			r.issued = 1'b1;
			r.wr = w;
			r.a = ad;
			r.d = dd;
		end else if (bd) begin
			r.issued = 1'b0;
			r.st = nx;
		end
		return r;
	endfunction : bus_step

	// Launch the timer, then move on when it expires
	function automatic fpv_pkg::fpv_host_st_t tmr_step(
		input fpv_pkg::fpv_host_st_t c,
		input logic                  td,
		input logic [`FPV_TW-1:0]    len,
		input fpv_pkg::fpv_mst_t     nx);
		fpv_pkg::fpv_host_st_t r;
		r = c;
		if (!c.issued) begin
			r.tgo = 1'b1;
			r.issued = 1'b1;
			r.tlen = len;
		end else if (td) begin
			r.issued = 1'b0;
			r.st = nx;
		end
		return r;
	endfunction : tmr_step

	always_comb begin
		next_s = s;
		next_s.go = 1'b0;
		next_s.tgo = 1'b0;
		next_s.done = 1'b0;
		if (ABORT) begin
			next_s.abt = 1'b1;
		end
		unique case (s.st)
			fpv_pkg::M_IDLE: begin
				next_s.abt = 1'b0;
				if (START) begin
					next_s.busy = 1'b1;
					next_s.fail = 1'b0;
					next_s.pcnt = '0;
					next_s.ecnt = '0;
					next_s.vaddr = `FPV_START_ADDR;
					next_s.pre = ERASE;
					next_s.pa = ERASE ? `FPV_START_ADDR : ADDR;
					next_s.pd = ERASE ? `FPV_PREPROG : DATA;
					next_s.st = fpv_pkg::P_SETUP;
				end
			end
			fpv_pkg::P_SETUP: next_s = bus_step(next_s, bus_done, 1'b1, s.pa,
				`FPV_CMD_SETUP_PROG, fpv_pkg::P_WRITE);
			fpv_pkg::P_WRITE: begin
				if (!s.issued && s.abt) begin
					next_s.st = fpv_pkg::R_FF1;
				end else begin
					next_s = bus_step(next_s, bus_done, 1'b1, s.pa, s.pd,
						fpv_pkg::P_PULSE);
				end
			end
			fpv_pkg::P_PULSE: next_s = tmr_step(next_s, tm_done, PROG_CYC,
				fpv_pkg::P_VCMD);
			fpv_pkg::P_VCMD: next_s = bus_step(next_s, bus_done, 1'b1, s.pa,
				`FPV_CMD_PROG_VERIFY, fpv_pkg::P_VWAIT);
			fpv_pkg::P_VWAIT: next_s = tmr_step(next_s, tm_done, VER_CYC,
				fpv_pkg::P_READ);
			fpv_pkg::P_READ: next_s = bus_step(next_s, bus_done, 1'b0, s.pa,
				`FPV_CMD_READ, fpv_pkg::P_CHECK);
			fpv_pkg::P_CHECK: begin
				if (bus_rd == s.pd) begin
					next_s.pcnt = '0;
					if (!s.pre) begin
						next_s.st = fpv_pkg::M_FIN;
					end else if (s.pa == LAST_ADDR) begin
						next_s.st = fpv_pkg::E_SET1;
					end else begin
						next_s.pa = s.pa + 1'b1;
						next_s.st = fpv_pkg::P_SETUP;
					end
				end else if (s.pcnt == PULSE_LAST) begin
					next_s.fail = 1'b1;
					next_s.st = fpv_pkg::M_FIN;
				end else begin
					next_s.pcnt = s.pcnt + 1'b1;
					next_s.st = fpv_pkg::P_SETUP;
				end
			end
			fpv_pkg::E_SET1: next_s = bus_step(next_s, bus_done, 1'b1, s.vaddr,
				`FPV_CMD_SETUP_ERASE, fpv_pkg::E_SET2);
			fpv_pkg::E_SET2: begin
				if (!s.issued && s.abt) begin
					next_s.st = fpv_pkg::R_FF1;
				end else begin
					next_s = bus_step(next_s, bus_done, 1'b1, s.vaddr,
						`FPV_CMD_SETUP_ERASE, fpv_pkg::E_ERASE);
				end
			end
			fpv_pkg::E_ERASE: next_s = tmr_step(next_s, tm_done, ERASE_CYC,
				fpv_pkg::E_VCMD);
			fpv_pkg::E_VCMD: next_s = bus_step(next_s, bus_done, 1'b1, s.vaddr,
				`FPV_CMD_ERASE_VERIFY, fpv_pkg::E_VWAIT);
			fpv_pkg::E_VWAIT: next_s = tmr_step(next_s, tm_done, VER_CYC,
				fpv_pkg::E_READ);
			fpv_pkg::E_READ: next_s = bus_step(next_s, bus_done, 1'b0, s.vaddr,
				`FPV_CMD_READ, fpv_pkg::E_CHECK);
			fpv_pkg::E_CHECK: begin
				if (bus_rd == `FPV_ERASED) begin
					if (s.vaddr == LAST_ADDR) begin
						next_s.st = fpv_pkg::M_FIN;
					end else begin
						next_s.vaddr = s.vaddr + 1'b1;
						next_s.st = fpv_pkg::E_VCMD;
					end
				end else if (s.ecnt == ERASE_LAST) begin
					next_s.fail = 1'b1;
					next_s.st = fpv_pkg::M_FIN;
				end else begin
					next_s.ecnt = s.ecnt + 1'b1;
					next_s.st = fpv_pkg::E_SET1;
				end
			end
			fpv_pkg::R_FF1: next_s = bus_step(next_s, bus_done, 1'b1, s.pa,
				`FPV_CMD_RESET, fpv_pkg::R_FF2);
			fpv_pkg::R_FF2: begin
				next_s = bus_step(next_s, bus_done, 1'b1, s.pa,
					`FPV_CMD_RESET, fpv_pkg::M_FIN);
				next_s.fail = 1'b1;
			end
			fpv_pkg::M_FIN: begin
				next_s = bus_step(next_s, bus_done, 1'b1, s.pa,
					`FPV_CMD_READ, fpv_pkg::M_IDLE);
				if (s.issued && bus_done) begin
					next_s.done = 1'b1;
					next_s.busy = 1'b0;
				end
			end
			default: next_s.st = fpv_pkg::M_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	fpv_bus u_bus (
		.clk      (CLK),
		.rst      (RST),
		.go       (s.go),
		.wr       (s.wr),
		.a        (s.a),
		.wd       (s.d),
		.done     (bus_done),
		.rd       (bus_rd),
		.fl_a     (FL_A),
		.fl_dq_o  (FL_DQ_O),
		.fl_dq_oe (FL_DQ_OE),
		.fl_dq_i  (FL_DQ_I),
		.fl_ce_n  (FL_CE_N),
		.fl_we_n  (FL_WE_N),
		.fl_oe_n  (FL_OE_N)
	);

	fpv_timer u_tmr (
		.clk  (CLK),
		.rst  (RST),
		.go   (s.tgo),
		.len  (s.tlen),
		.done (tm_done)
	);

	assign BUSY = s.busy;
	assign DONE = s.done;
	assign FAIL = s.fail;
	assign FL_VPP_EN = s.busy;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_arm_prog;
		(s.st == fpv_pkg::P_SETUP && s.issued && bus_done)
			|=> s.st == fpv_pkg::P_WRITE ##1 s.go || s.st == fpv_pkg::R_FF1;
	endproperty
	a_arm_prog: assert property (p_arm_prog)
		else $error("program write does not follow set-up");
	property p_pulse_len;
		(s.tgo && s.st == fpv_pkg::P_PULSE) |-> s.tlen == PROG_CYC;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("program pulse length wrong");
	property p_pulse_cap;
		s.pcnt <= PULSE_LAST;
	endproperty
	a_pulse_cap: assert property (p_pulse_cap)
		else $error("too many program pulses");
	property p_pverify;
		(s.go && s.st == fpv_pkg::P_VCMD)
			|-> s.wr && s.d == `FPV_CMD_PROG_VERIFY;
	endproperty
	a_pverify: assert property (p_pverify)
		else $error("program verify byte wrong");
	property p_everify;
		(s.go && s.st == fpv_pkg::E_VCMD)
			|-> s.d == `FPV_CMD_ERASE_VERIFY && s.a == s.vaddr;
	endproperty
	a_everify: assert property (p_everify)
		else $error("erase verify address or byte wrong");
	property p_erase_twice;
		(s.st == fpv_pkg::E_SET1 && s.issued && bus_done)
			|=> s.st == fpv_pkg::E_SET2;
	endproperty
	a_erase_twice: assert property (p_erase_twice)
		else $error("second erase set-up missing");
	property p_resume;
		(s.st == fpv_pkg::E_CHECK && bus_rd != `FPV_ERASED
			&& s.ecnt != ERASE_LAST)
			|=> s.st == fpv_pkg::E_SET1 && $stable(s.vaddr);
	endproperty
	a_resume: assert property (p_resume)
		else $error("verification does not resume at kept address");
	property p_cmd_bits;
		(s.go && s.wr && s.st != fpv_pkg::P_WRITE)
			|-> s.d[4:0] == 5'h00 || s.d == `FPV_CMD_RESET;
	endproperty
	a_cmd_bits: assert property (p_cmd_bits)
		else $error("illegal command byte");
	property p_abort;
		(s.st == fpv_pkg::R_FF2 && s.issued && bus_done)
			|=> s.st == fpv_pkg::M_FIN ##1 s.go && s.d == `FPV_CMD_READ;
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort not followed by read command");
	property p_preprog;
		(s.go && s.st == fpv_pkg::P_WRITE && s.pre) |-> s.d == `FPV_PREPROG;
	endproperty
	a_preprog: assert property (p_preprog)
		else $error("pre-programming data not zero");
	property p_erase_start;
		(START && ERASE && s.st == fpv_pkg::M_IDLE)
			|=> s.vaddr == `FPV_START_ADDR && s.pre;
	endproperty
	a_erase_start: assert property (p_erase_start)
		else $error("erase does not start at first address");
	property p_finish_read;
		s.done |-> s.wr && s.d == `FPV_CMD_READ && !s.busy;
	endproperty
	a_finish_read: assert property (p_finish_read)
		else $error("finish without read command");

	c_prog_ok: cover property (s.done && !s.fail && !s.pre);
	c_erase_ok: cover property (s.done && !s.fail && s.pre);
	c_abort: cover property (s.st == fpv_pkg::R_FF2 && bus_done);
	c_reerase: cover property (s.st == fpv_pkg::E_SET1 && s.ecnt != '0);
endmodule : fpv_host

/* File: hw/fpv_pkg.sv */
// Types of the flash programming host
`include "fpv_defines.svh"
package fpv_pkg;
	typedef enum logic [1:0] {BP_IDLE, BP_SET, BP_STRB, BP_HOLD} fpv_bph_t;
	typedef struct packed {
		fpv_bph_t              ph;
		logic [7:0]            cnt;
		logic                  wr;
		logic                  ce_n;
		logic                  we_n;
		logic                  oe_n;
		logic                  dq_oe;
		logic [`FPV_AW-1:0]    a;
		logic [7:0]            wd;
		logic [7:0]            rd;
		logic                  done;
	} fpv_bus_st_t;
	typedef struct packed {
		logic [`FPV_TW-1:0]    cnt;
		logic                  run;
		logic                  done;
	} fpv_tmr_st_t;
	typedef enum logic [4:0] {
		M_IDLE, P_SETUP, P_WRITE, P_PULSE, P_VCMD, P_VWAIT, P_READ,
		P_CHECK, E_SET1, E_SET2, E_ERASE, E_VCMD, E_VWAIT, E_READ,
		E_CHECK, R_FF1, R_FF2, M_FIN
	} fpv_mst_t;
	typedef struct packed {
		fpv_mst_t              st;
		logic                  issued;
		logic                  go;
		logic                  wr;
		logic [`FPV_AW-1:0]    a;
		logic [7:0]            d;
		logic [`FPV_AW-1:0]    pa;
		logic [7:0]            pd;
		logic [`FPV_AW-1:0]    vaddr;
		logic [`FPV_PCW-1:0]   pcnt;
		logic [`FPV_ECW-1:0]   ecnt;
		logic                  pre;
		logic                  abt;
		logic                  busy;
		logic                  done;
		logic                  fail;
		logic                  tgo;
		logic [`FPV_TW-1:0]    tlen;
	} fpv_host_st_t;
endpackage : fpv_pkg

/* File: hw/fpv_timer.sv */
// Cycle timer for program, erase and verify delays
`include "fpv_defines.svh"
module fpv_timer (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Control
	input  wire logic                 go,
	input  wire logic [`FPV_TW-1:0]   len,
	// Status
	output logic                      done
);
	fpv_pkg::fpv_tmr_st_t s;
	fpv_pkg::fpv_tmr_st_t next_s;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (go) begin
			next_s.cnt = len;
			next_s.run = 1'b1;
		end else if (s.run) begin
			if (s.cnt <= `FPV_TW'(1)) begin
				next_s.run = 1'b0;
				next_s.done = 1'b1;
			end else begin
				next_s.cnt = s.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;
endmodule : fpv_timer

/* File: verif/fpv_flash_model.sv */
// Behavioural model of the byte-wide flash memory
`include "fpv_defines.svh"
module fpv_flash_model #(
	parameter int DEPTH     = 4,
	parameter int ERASE_CYC = 20
) (
	// Clock
	input  wire logic               clk,
	// Flash pins
	input  wire logic [`FPV_AW-1:0] a,
	input  wire logic [7:0]         dq_o,
	input  wire logic               dq_oe,
	output logic      [7:0]         dq_i,
	input  wire logic               ce_n,
	input  wire logic               we_n,
	input  wire logic               oe_n,
	input  wire logic               vpp
);
	localparam logic [2:0] S_RD = 3'h0, S_SE = 3'h1, S_ER = 3'h2;
	localparam logic [2:0] S_EV = 3'h3, S_SP = 3'h4, S_PR = 3'h5;
	localparam logic [2:0] S_PV = 3'h6, S_RS = 3'h7;
	logic [7:0]         mem [DEPTH];
	logic [2:0]         st = S_RD;
	logic               we_q = 1'b1;
	logic [`FPV_AW-1:0] la = '0, ea = '0, pa = '0, ra;
	logic [7:0]         pd, last = 8'h00;
	int                 cyc, pulses, need = 1, erases, estep, errs, aborts;
	int                 vlog [$];

	initial foreach (mem[i]) mem[i] = 8'hff;

	// Margin reads of the latched byte in the verify states
	assign ra = (st == S_EV) ? ea : (st == S_PV) ? pa : a;
	assign dq_i = (!ce_n && !oe_n) ? mem[ra] : ~last;

	task automatic vfy;
		ea = la;
		vlog.push_back(int'(la));
		st = S_EV;
	endtask : vfy

	task automatic cmd(input logic [7:0] d);
		if (!vpp || !dq_oe)
			errs++;
		if (st == S_SE || st == S_SP) begin
			if (d == 8'hff)
				st = S_RS;
			else if (st == S_SE && d == 8'h20) begin
				st = S_ER;
				cyc = 0;
			end else if (st == S_SP) begin
				if (la !== pa)
					pulses = 0;
				pa = la;
				pd = d;
				st = S_PR;
				cyc = 0;
			end else
				errs++;
		end else if (st == S_RS) begin
			if (d == 8'hff)
				aborts++;
			else
				errs++;
			st = S_RD;
		end else if (st == S_PR) begin
			if (d != 8'hc0 || cyc < 100 || cyc > 130)
				errs++;
			pulses++;
			if (pulses >= need)
				mem[pa] = mem[pa] & pd;
			st = S_PV;
		end else if (st == S_ER) begin
			if (d != 8'ha0 || cyc < ERASE_CYC)
				errs++;
			erases++;
			for (int i = 0; i < DEPTH; i++)
				if (erases > i * estep)
					mem[i] = 8'hff;
			vfy();
		end else begin
			if (d[4:0] != 5'h00)
				errs++;
			case (d)
			8'h00: st = S_RD;
			8'h40: st = S_SP;
			8'h20: begin
				if (st != S_EV)
					foreach (mem[i])
						if (mem[i] != 8'h00)
							errs++;
				st = S_SE;
			end
			8'ha0: if (st == S_EV) vfy(); else errs++;
			default: errs++;
			endcase
		end
	endtask : cmd

	// State changes follow sampled write strobe edges
	always @(posedge clk) begin
		cyc++;
		if (!ce_n && !oe_n)
			last = dq_i;
		if (we_q && !we_n && !ce_n)
			la = a;
		if (!we_q && we_n && !ce_n)
			cmd(dq_o);
		we_q = we_n;
	end
endmodule : fpv_flash_model

/* File: verif/fpv_host_tb.sv */
// Self-checking bench of the flash programming host
`include "fpv_defines.svh"
module fpv_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk, rst, start, erase, abort;
	logic [`FPV_AW-1:0] addr;
	logic [7:0]         data, dq_o, dq_i;
	logic               busy, done, fail, dq_oe, ce_n, we_n, oe_n, vpp;
	logic [`FPV_AW-1:0] fa;
	int                 fail_count = 0, comparisons = 0;

	fpv_host #(.LAST_ADDR(`FPV_AW'(3)), .ERASE_CYC(`FPV_TW'(20)),
		.MAX_ERASE(`FPV_ECW'(8))) dut (.CLK(clk), .RST(rst),
		.START(start), .ERASE(erase), .ADDR(addr), .DATA(data),
		.ABORT(abort), .BUSY(busy), .DONE(done), .FAIL(fail), .FL_A(fa),
		.FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_i), .FL_CE_N(ce_n),
		.FL_WE_N(we_n), .FL_OE_N(oe_n), .FL_VPP_EN(vpp));

	fpv_flash_model #(.DEPTH(4), .ERASE_CYC(20)) mdl (.clk(clk), .a(fa),
		.dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .vpp(vpp));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic test_done;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %0h want %0h", $time, seen, exp);
		end
	endtask : check

	task automatic run_op(input logic er, input logic [16:0] ad,
		input logic [7:0] d, input logic ab);
		@(posedge clk);
		#1;
		start = 1'b1;
		erase = er;
		addr = ad;
		data = d;
		@(posedge clk);
		#1;
		start = 1'b0;
		abort = ab;
		@(posedge clk);
		#1;
		abort = 1'b0;
		check(32'({busy, vpp}), 32'h3);
		for (int i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		check(32'(done), 1);
		check(32'({busy, vpp}), 0);
	endtask : run_op

	task automatic t_prog;
		mdl.need = 3;
		run_op(1'b0, 17'h3, 8'h5a, 1'b0);
		check(32'(fail), 0);
		check(32'(mdl.pulses), 3);
		check(32'(mdl.mem[3]), 8'h5a);
		mdl.need = 1;
		run_op(1'b0, 17'h0, 8'ha5, 1'b0);
		check(32'(mdl.mem[0]), 8'ha5);
		check(32'(mdl.st), 0);
	endtask : t_prog

	task automatic t_limit;
		mdl.need = 26;
		run_op(1'b0, 17'h2, 8'h0f, 1'b0);
		check(32'(fail), 1);
		check(32'(mdl.pulses), 25);
		check(32'(mdl.mem[2]), 8'hff);
	endtask : t_limit

	task automatic t_abort;
		mdl.need = 1;
		run_op(1'b0, 17'h1, 8'h00, 1'b1);
		check(32'(fail), 1);
		check(32'(mdl.aborts), 1);
		check(32'(mdl.mem[1]), 8'hff);
		check(32'(mdl.st), 0);
	endtask : t_abort

	task automatic t_erase;
		int exp_v [7] = '{0, 1, 1, 2, 2, 3, 3};
		mdl.estep = 1;
		mdl.erases = 0;
		mdl.vlog.delete();
		run_op(1'b1, 17'h0, 8'h00, 1'b0);
		check(32'(fail), 0);
		check(32'(mdl.erases), 4);
		check(32'(mdl.vlog.size()), 7);
		foreach (exp_v[i])
			check(32'(mdl.vlog[i]), 32'(exp_v[i]));
		check(32'(mdl.mem[3]), 8'hff);
		check(32'(mdl.st), 0);
	endtask : t_erase

	task automatic t_erase_limit;
		mdl.estep = 100;
		mdl.erases = 0;
		run_op(1'b1, 17'h0, 8'h00, 1'b0);
		check(32'(fail), 1);
		check(32'(mdl.erases), 8);
		check(32'(mdl.errs), 0);
	endtask : t_erase_limit

	task automatic t_reset;
		@(posedge clk);
		#1;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(32'({busy, ce_n, we_n, dq_oe, vpp}), 32'h0c);
		rst = 1'b0;
	endtask : t_reset

	initial begin
		#(40000 * 100);
		fail_count++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		start = 1'b0;
		erase = 1'b0;
		abort = 1'b0;
		addr = '0;
		data = 8'h00;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		t_prog();
		t_limit();
		t_abort();
		t_erase();
		t_erase_limit();
		t_reset();
		test_done();
	end
endmodule : fpv_host_tb
